// File: rtl/dsr_pkg.sv
// package for the diagnostic status report packer: layouts, codes, register map
package dsr_pkg;
  // report kinds as written by software to the request register
  localparam logic [1:0] DSR_KIND_CHAN = 2'h0;
  localparam logic [1:0] DSR_KIND_BUS = 2'h1;
  localparam logic [1:0] DSR_KIND_VID = 2'h2;
  localparam logic [1:0] DSR_KIND_BAD = 2'h3;

  // register byte offsets
  localparam logic [7:0] DSR_OFF_REQ = 8'h00;
  localparam logic [7:0] DSR_OFF_STAT = 8'h04;
  localparam logic [7:0] DSR_OFF_W0 = 8'h08;
  localparam logic [7:0] DSR_OFF_W1 = 8'h0c;

  // status register bit positions
  localparam int DSR_STAT_DONE = 0;
  localparam int DSR_STAT_ERR = 1;
  localparam int DSR_STAT_KIND = 4;
  localparam int DSR_STAT_LEN = 8;

  // report lengths in bits
  localparam logic [7:0] DSR_LEN_CHAN = 8'h18;
  localparam logic [7:0] DSR_LEN_BUS = 8'h18;
  localparam logic [7:0] DSR_LEN_VID = 8'h38;

  // reserved fill values
  localparam logic [1:0] DSR_RSV_CHAN = 2'h3;
  localparam logic [2:0] DSR_RSV_BUS = 3'h7;
  localparam logic [2:0] DSR_RSV_VID_HEAD = 3'h7;
  localparam logic [4:0] DSR_RSV_VID_TAIL = 5'h1f;

  // video field codes
  localparam logic [1:0] DSR_CONN_NONE = 2'h0;
  localparam logic [1:0] DSR_CONN_SINK = 2'h1;
  localparam logic [1:0] DSR_CONN_RPT = 2'h2;
  localparam logic [1:0] DSR_SINK_NONPROT = 2'h0;
  localparam logic [1:0] DSR_SINK_COMPLIANT = 2'h1;
  localparam logic [1:0] DSR_SINK_REVOKED = 2'h2;
  localparam logic [7:0] DSR_RATE_23976 = 8'h01;
  localparam logic [7:0] DSR_RATE_24 = 8'h02;
  localparam logic [7:0] DSR_RATE_2997 = 8'h04;
  localparam logic [7:0] DSR_RATE_30 = 8'h05;
  localparam logic [7:0] DSR_RATE_5994 = 8'h07;
  localparam logic [7:0] DSR_RATE_60 = 8'h08;
  localparam logic [1:0] DSR_ASPECT_4_3 = 2'h0;
  localparam logic [1:0] DSR_ASPECT_16_9 = 2'h1;

  // channel status inputs
  typedef struct packed {
    logic digital;
    logic authorized;
    logic purchasable;
    logic purchased;
    logic preview;
    logic blocked;
    logic [15:0] number;
  } dsr_chan_t;

  // serial-bus port status inputs
  typedef struct packed {
    logic loop_found;
    logic is_root;
    logic is_cycle_master;
    logic port1_attached;
    logic port2_attached;
    logic [15:0] attached_node_count;
  } dsr_bus_t;

  // video port status inputs
  typedef struct packed {
    logic [1:0] conn_state;
    logic host_protection_on;
    logic [1:0] sink_protection_state;
    logic [15:0] h_lines;
    logic [15:0] v_lines;
    logic [7:0] rate_code;
    logic [1:0] aspect_code;
    logic progressive;
  } dsr_vid_t;

  // whole register state of the block
  typedef struct packed {
    logic [55:0] report;
    logic [1:0] kind;
    logic [7:0] len;
    logic done;
    logic err;
    logic [31:0] prdata;
    logic pready;
  } dsr_state_t;

  localparam dsr_state_t DSR_STATE_RST = '{report: 56'h0, kind: 2'h0, len: 8'h0,
                                          done: 1'b0, err: 1'b0, prdata: 32'h0, pready: 1'b0};
endpackage

// File: rtl/dsr_packer.sv
// diagnostic status report packer with apb register access
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module dsr_packer
  import dsr_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic REPORT_ERROR,
  input wire dsr_chan_t CHAN_STATUS,
  input wire dsr_bus_t BUS_STATUS,
  input wire dsr_vid_t VID_STATUS,
  output logic REPORT_DONE
);

  dsr_state_t s_r;
  dsr_state_t s_nxt;
  logic [55:0] chan_img;
  logic [55:0] bus_img;
  logic [55:0] vid_img;
  logic setup;
  logic wr_req;
  logic [1:0] chan_rsv;
  logic [5:0] chan_flags;
  logic [15:0] chan_num;
  logic [2:0] bus_rsv;
  logic [4:0] bus_flags;
  logic [15:0] bus_cnt;
  logic [2:0] vid_head;
  logic [1:0] vid_conn;
  logic vid_hprot;
  logic [1:0] vid_sprot;
  logic [15:0] vid_h;
  logic [15:0] vid_v;
  logic [7:0] vid_rate;
  logic [1:0] vid_aspect;
  logic vid_scan;
  logic [4:0] vid_tail;
  logic [31:0] stat_word;

  // channel report fields, one wire each so a swapped bit shows up by name
  assign chan_rsv = DSR_RSV_CHAN;
  assign chan_flags[5] = CHAN_STATUS.digital;
  assign chan_flags[4] = CHAN_STATUS.authorized;
  assign chan_flags[3] = CHAN_STATUS.purchasable;
  assign chan_flags[2] = CHAN_STATUS.purchased;
  assign chan_flags[1] = CHAN_STATUS.preview;
  assign chan_flags[0] = CHAN_STATUS.blocked;
  assign chan_num = CHAN_STATUS.number;

  // channel image left aligned: bit 55 is the first bit sent
  assign chan_img = {chan_rsv, chan_flags, chan_num, 32'h0};

  // serial-bus port report fields
  assign bus_rsv = DSR_RSV_BUS;
  assign bus_flags[4] = BUS_STATUS.loop_found;
  assign bus_flags[3] = BUS_STATUS.is_root;
  assign bus_flags[2] = BUS_STATUS.is_cycle_master;
  assign bus_flags[1] = BUS_STATUS.port1_attached;
  assign bus_flags[0] = BUS_STATUS.port2_attached;
  assign bus_cnt = BUS_STATUS.attached_node_count;

  // bus image, same alignment; the unused tail reads as zero
  assign bus_img = {bus_rsv, bus_flags, bus_cnt, 32'h0};

  // video report fields; codes pass through, reserved ones are the source's business
  assign vid_head = DSR_RSV_VID_HEAD;
  assign vid_conn = VID_STATUS.conn_state;
  assign vid_hprot = VID_STATUS.host_protection_on;
  assign vid_sprot = VID_STATUS.sink_protection_state;
  assign vid_h = VID_STATUS.h_lines;
  assign vid_v = VID_STATUS.v_lines;
  assign vid_rate = VID_STATUS.rate_code;
  assign vid_aspect = VID_STATUS.aspect_code;
  assign vid_scan = VID_STATUS.progressive;
  assign vid_tail = DSR_RSV_VID_TAIL;

  // video image fills all 56 bits, trailing reserved group last
  assign vid_img = {vid_head, vid_conn, vid_hprot, vid_sprot, vid_h, vid_v,
                    vid_rate, vid_aspect, vid_scan, vid_tail};

  // status word built from the named bit positions
  always_comb begin
    stat_word = 32'h0;
    stat_word[DSR_STAT_DONE] = s_r.done;
    stat_word[DSR_STAT_ERR] = s_r.err;
    stat_word[DSR_STAT_KIND +: 2] = s_r.kind;
    stat_word[DSR_STAT_LEN +: 8] = s_r.len;
  end

  // apb answers in the access cycle after setup: no wait states
  assign setup = PSEL && !PENABLE;
  assign wr_req = setup && PWRITE && (PADDR == DSR_OFF_REQ);

  always_comb begin
    s_nxt = s_r;
    s_nxt.pready = setup;
    if (setup && !PWRITE) begin
      case (PADDR)
        DSR_OFF_STAT: s_nxt.prdata = stat_word;
        DSR_OFF_W0: s_nxt.prdata = s_r.report[55:24];
        DSR_OFF_W1: s_nxt.prdata = {s_r.report[23:0], 8'h0};
        default: s_nxt.prdata = 32'h0;
      endcase
    end
    // request accepted: every field taken from the same cycle
    if (wr_req) begin
      s_nxt.kind = PWDATA[1:0];
      s_nxt.done = 1'b1;
      s_nxt.err = 1'b0;
      if (REPORT_ERROR) begin
        s_nxt.err = 1'b1;
        s_nxt.len = 8'h0;
        s_nxt.report = 56'h0;
      end else begin
        case (PWDATA[1:0])
          DSR_KIND_CHAN: begin
            s_nxt.report = chan_img;
            s_nxt.len = DSR_LEN_CHAN;
          end
          DSR_KIND_BUS: begin
            s_nxt.report = bus_img;
            s_nxt.len = DSR_LEN_BUS;
          end
          DSR_KIND_VID: begin
            s_nxt.report = vid_img;
            s_nxt.len = DSR_LEN_VID;
          end
          default: begin
            s_nxt.err = 1'b1;
            s_nxt.len = 8'h0;
            s_nxt.report = 56'h0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      s_r <= DSR_STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign PRDATA = s_r.prdata;
  assign PREADY = s_r.pready;
  assign PSLVERR = 1'b0;
  assign REPORT_DONE = s_r.done;

endmodule

// File: verif/dsr_packer_checker.sv
// port assertions for the report packer
`timescale 1ns/1ps
module dsr_packer_checker
  import dsr_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic REPORT_ERROR,
  input wire dsr_chan_t CHAN_STATUS,
  input wire logic REPORT_DONE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  // setup phases of interest
  wire su = PSEL && !PENABLE;
  wire wq = su && PWRITE && PADDR == DSR_OFF_REQ;
  wire rq = wq && !REPORT_ERROR;
  wire r0 = su && !PWRITE && PADDR == DSR_OFF_W0;
  wire r1 = su && !PWRITE && PADDR == DSR_OFF_W1;
  property p_ready; su |=> PREADY; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_idle; !PSEL |=> !PREADY; endproperty
  a_idle: assert property (p_idle) else $error("ready without request");
  property p_done; wq |=> REPORT_DONE [*2]; endproperty
  a_done: assert property (p_done) else $error("done not set");
  property p_hold; REPORT_DONE |=> REPORT_DONE; endproperty
  a_hold: assert property (p_hold) else $error("done dropped");
  // back-to-back read of the image after a request
  property p_chan; rq && PWDATA[1:0] == DSR_KIND_CHAN ##2 r0 |=>
    PRDATA[31:30] == 2'h3 && PRDATA[23:8] == $past(CHAN_STATUS.number, 3); endproperty
  a_chan: assert property (p_chan) else $error("channel image wrong");
  property p_bus; rq && PWDATA[1:0] == DSR_KIND_BUS ##2 r0 |=> PRDATA[31:29] == 3'h7; endproperty
  a_bus: assert property (p_bus) else $error("bus reserved wrong");
  property p_vid; rq && PWDATA[1:0] == DSR_KIND_VID ##2 r0 |=> PRDATA[31:29] == 3'h7; endproperty
  a_vid: assert property (p_vid) else $error("video head wrong");
  property p_tail; rq && PWDATA[1:0] == DSR_KIND_VID ##4 r1 |=> PRDATA[12:8] == 5'h1f; endproperty
  a_tail: assert property (p_tail) else $error("video tail wrong");
  c_img: cover property (rq ##2 r0);
  c_tail: cover property (rq ##4 r1);
  c_err: cover property (wq && REPORT_ERROR);
endmodule

// File: verif/dsr_card_model.sv
// card side: status moves on right after each taken request
`timescale 1ns/1ps
module dsr_card_model
  import dsr_pkg::*;
(
  input wire logic CLOCK,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  output dsr_chan_t CHAN_STATUS = '0,
  output dsr_bus_t BUS_STATUS = '0,
  output dsr_vid_t VID_STATUS = '0,
  output logic REPORT_ERROR = 1'b0
);
  // changing after the capture edge exposes a late or split capture
  always @(posedge CLOCK) begin
    if (PSEL && !PENABLE && PWRITE && PADDR == DSR_OFF_REQ) begin
      CHAN_STATUS <= 22'($urandom);
      BUS_STATUS <= 21'($urandom);
      VID_STATUS <= 48'({$urandom, $urandom});
      REPORT_ERROR <= ($urandom % 4) == 0;
    end
  end
endmodule

// File: verif/tb.sv
// self-checking bench for the report packer
`timescale 1ns/1ps
module tb;
  import dsr_pkg::*;
  logic CLOCK = 1'b0, RSTN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h0;
  logic [31:0] PWDATA = 32'h0, PRDATA, q;
  logic PREADY, PSLVERR, REPORT_ERROR, REPORT_DONE;
  dsr_chan_t CHAN_STATUS;
  dsr_bus_t BUS_STATUS;
  dsr_vid_t VID_STATUS;
  int miscompares = 0, cmp_count = 0;
  always #4 CLOCK = ~CLOCK;
  dsr_packer dut (.CLOCK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
    .REPORT_ERROR, .CHAN_STATUS, .BUS_STATUS, .VID_STATUS, .REPORT_DONE);
  dsr_card_model card (.CLOCK, .PSEL, .PENABLE, .PWRITE, .PADDR, .CHAN_STATUS, .BUS_STATUS, .VID_STATUS,
    .REPORT_ERROR);
  task complete_run;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // one transfer, held until ready is sampled; no release, so calls chain back to back
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (PREADY !== 1'b1 && n < 16);
    q = PRDATA;
    chk("slverr", 32'h0, {31'h0, PSLVERR});
    if (PREADY !== 1'b1) begin
      miscompares++;
      complete_run;
    end
  endtask
  function automatic logic [55:0] rep(logic [1:0] k, logic e, dsr_chan_t c, dsr_bus_t b, dsr_vid_t v);
    if (e || k == 2'h3) return 56'h0;
    if (k == 2'h0) return {2'h3, c, 32'h0};
    if (k == 2'h1) return {3'h7, b, 32'h0};
    return {3'h7, v, 5'h1f};
  endfunction
  function automatic logic [31:0] stat(logic [1:0] k, logic e);
    logic er;
    er = e || k == 2'h3;
    return {16'h0, er ? 8'h0 : (k == 2'h2 ? 8'h38 : 8'h18), 2'h0, k, 2'h0, er, 1'b1};
  endfunction
  // status is snapshotted before the capture edge; the card changes it right after
  task req(input logic [1:0] k);
    logic [55:0] r;
    logic [31:0] s;
    r = rep(k, REPORT_ERROR, CHAN_STATUS, BUS_STATUS, VID_STATUS);
    s = stat(k, REPORT_ERROR);
    apb(1'b1, DSR_OFF_REQ, {30'h0, k});
    apb(1'b0, DSR_OFF_W0, 32'h0);
    chk("w0", r[55:24], q);
    apb(1'b0, DSR_OFF_W1, 32'h0);
    chk("w1", {r[23:0], 8'h0}, q);
    apb(1'b0, DSR_OFF_STAT, 32'h0);
    chk("stat", s, q);
  endtask
  initial begin
    void'($urandom(20));
    repeat (6) @(posedge CLOCK);
    RSTN <= 1'b1;
    @(posedge CLOCK);
    chk("done", 32'h0, {31'h0, REPORT_DONE});
    apb(1'b1, DSR_OFF_STAT, 32'hffffffff);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, q);
    apb(1'b0, DSR_OFF_STAT, 32'h0);
    chk("stat ro", 32'h0, q);
    for (int i = 0; i < 40; i++) req(i < 4 ? i[1:0] : 2'($urandom));
    chk("done", 32'h1, {31'h0, REPORT_DONE});
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    complete_run;
  end
endmodule
bind dsr_packer dsr_packer_checker u_chk (.CLOCK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
  .PREADY, .REPORT_ERROR, .CHAN_STATUS, .REPORT_DONE);
